// *** bench/stc_chk_sva.sv ***
/* Port checker for the timer cluster, bound into stc_timer_cluster.
   Assumes one clk domain with async active-low rst_n. */
`timescale 1ns/1ps
module stc_chk_sva
  import stc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire stc_pwr_t pwr_state,
  input wire stc_rld_cfg_t [STC_NUM_RLD-1:0] rld_cfg,
  input wire stc_thr_cfg_t [STC_NUM_THR-1:0] thr_cfg,
  input wire logic [STC_WAKE_W-1:0] wake_count,
  input wire logic wake_req,
  input wire logic [STC_NUM_RLD-1:0][STC_RLD_W-1:0] rld_count,
  input wire logic [STC_NUM_RLD-1:0] rld_irq,
  input wire logic [STC_NUM_DUAL-1:0][STC_DUAL_W-1:0] dual_count,
  input wire logic dual_irq,
  input wire logic [STC_SLOW_W-1:0] slow_count,
  input wire logic [STC_NUM_THR-1:0] slow_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_RLD_IRQ: assert property (
    rld_irq[0] |-> rld_count[0] == 32'h0 && $past(rld_count[0]) == 32'h1)
    else $error("reload irq without a 1 to 0 step");
  AST_RLD_RELOAD: assert property (
    $past(rld_count[0]) == 32'h0 && rld_count[0] != 32'h0 |-> rld_count[0] == $past(rld_cfg[0].reload))
    else $error("reload counter left zero with a wrong value");
  AST_RLD_DEC: assert property (
    $past(pwr_state) == STC_PWR_ACTIVE && $past(rld_count[1]) != 32'h0 && $changed(rld_count[1])
    |-> rld_count[1] == $past(rld_count[1]) - 32'h1)
    else $error("second reload counter stepped by other than one");
  AST_HOLD: assert property (pwr_state == STC_PWR_RETENTION |=> $stable(rld_count))
    else $error("reload counts moved in retention");
  AST_CLEAR: assert property (
    pwr_state == STC_PWR_HIBERNATION |=> rld_count == '0 && dual_count == '0 && slow_count == '0)
    else $error("timer counts not cleared in hibernation");
  AST_DUAL_IRQ: assert property (dual_irq |-> dual_count[0] == '0 || dual_count[1] == '0)
    else $error("dual irq with no channel at zero");
  AST_SLOW_THR: assert property (
    slow_irq[0] |-> slow_count == thr_cfg[0].value && $past(slow_count) == thr_cfg[0].value + 40'h1)
    else $error("threshold irq off its crossing");
  AST_WAKE: assert property ($past(wake_count) == 40'h1 && wake_count == '0 |-> wake_req)
    else $error("wakeup expiry without wake request");
endmodule // stc_chk_sva

bind stc_timer_cluster stc_chk_sva i_chk (.clk, .rst_n, .pwr_state, .rld_cfg, .thr_cfg,
  .wake_count, .wake_req, .rld_count, .rld_irq, .dual_count, .dual_irq, .slow_count, .slow_irq);

// *** bench/stc_core_rd.sv ***
/* Core-side reader of the slow count: two samples, a third on disagreement.
   Assumes slow_count is a registered output on clk. */
`timescale 1ns/1ps
module stc_core_rd
  import stc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [STC_SLOW_W-1:0] slow_count,
  output logic [STC_SLOW_W-1:0] val,
  output logic done
);
  logic [1:0] ph_ff;
  logic [STC_SLOW_W-1:0] first_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_ff <= 2'h0;
      done <= 1'h0;
      first_ff <= '0;
      val <= '0;
    end else begin
      // Counts cross from a slow domain, so one sample alone may be torn
      done <= ph_ff[1] || (ph_ff[0] && slow_count == first_ff);
      ph_ff <= start ? 2'h1 : {ph_ff[0] && slow_count != first_ff, 1'h0};
      first_ff <= slow_count;
      val <= slow_count;
    end
  end
endmodule // stc_core_rd

// *** bench/tb.sv ***
/* Self-checking testbench for stc_timer_cluster and a slow count reader.
   Timer clock levels are stepped by the bench on a 200 MHz clk. */
`timescale 1ns/1ps
module tb
  import stc_pkg::*;
;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic lp_xtal_clk = 1'h0, lp_internal_rc_osc_clk = 1'h0, lp_src_rc = 1'h0;
  logic mp_xtal_clk = 1'h0, mp_internal_rc_osc_clk = 1'h0, mp_src_rc = 1'h0;
  logic wake_enable = 1'h0, wake_load = 1'h0, ext_wake_pin = 1'h0, cmp_wake = 1'h0;
  logic slow_enable = 1'h0, slow_load = 1'h0, rd_start = 1'h0, wake_req, dual_irq, rd_done;
  stc_pwr_t pwr_state = STC_PWR_ACTIVE;
  logic [STC_WAKE_W-1:0] wake_value = '0, wake_count;
  logic [STC_SLOW_W-1:0] slow_value = '0, slow_count, rd_val;
  stc_rld_cfg_t [STC_NUM_RLD-1:0] rld_cfg = '0;
  stc_dual_cfg_t [STC_NUM_DUAL-1:0] dual_cfg = '0;
  stc_thr_cfg_t [STC_NUM_THR-1:0] thr_cfg = '0;
  logic [STC_NUM_RLD-1:0][STC_RLD_W-1:0] rld_count;
  logic [STC_NUM_RLD-1:0] rld_irq;
  logic [STC_NUM_DUAL-1:0][STC_DUAL_W-1:0] dual_count;
  logic [STC_NUM_THR-1:0] slow_irq;
  wire [6:0] ev = {slow_irq[2], wake_req, slow_irq[1:0], dual_irq, rld_irq};
  int fails = 0, n_checks = 0;
  int evn [7] = '{default: 0};

  stc_timer_cluster i_dut (.clk, .rst_n, .lp_xtal_clk, .lp_internal_rc_osc_clk, .lp_src_rc,
    .mp_xtal_clk, .mp_internal_rc_osc_clk, .mp_src_rc, .pwr_state, .wake_enable, .wake_load,
    .wake_value, .ext_wake_pin, .cmp_wake, .rld_cfg, .dual_cfg, .slow_enable, .slow_load,
    .slow_value, .thr_cfg, .wake_count, .wake_req, .rld_count, .rld_irq, .dual_count,
    .dual_irq, .slow_count, .slow_irq);
  stc_core_rd i_rd (.clk, .rst_n, .start(rd_start), .slow_count, .val(rd_val), .done(rd_done));

  always #2.5 clk = ~clk;
  // Pulses are one cycle wide, so they are tallied here rather than sampled later
  always @(posedge clk) begin
    foreach (evn[i])
      if (ev[i] === 1'h1) evn[i]++;
  end

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic step(input bit lp, input int n);
    repeat (n) begin
      if (lp) {lp_internal_rc_osc_clk, lp_xtal_clk} = lp_src_rc ? 2'h2 : 2'h1;
      else {mp_internal_rc_osc_clk, mp_xtal_clk} = mp_src_rc ? 2'h2 : 2'h1;
      tick();
      {lp_internal_rc_osc_clk, lp_xtal_clk, mp_internal_rc_osc_clk, mp_xtal_clk} = 4'h0;
      tick();
    end
  endtask
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] act);
    n_checks++;
    if (act !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, act);
      fails++;
    end
  endtask
  task automatic end_sim;
    if (fails == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wait_rd;
    for (int i = 0; i < 8 && rd_done !== 1'h1; i++) tick();
    if (rd_done !== 1'h1) begin
      fails++;
      end_sim();
    end
  endtask

  task automatic t_reload;
    rld_cfg[0] = {1'h1, 1'h1, 32'h2};
    rld_cfg[1] = {1'h1, 1'h0, 32'h3};
    step(1'h1, 2);
    chk("rld_count0", 0, rld_count[0]);
    step(1'h0, 4);
    chk("rld_count0", 2, rld_count[0]);
    chk("rld_count1", 0, rld_count[1]);
    chk("rld_irq0", 1, evn[0]);
    chk("rld_irq1", 0, evn[1]);
    pwr_state = STC_PWR_RETENTION;
    step(1'h0, 3);
    chk("rld_count0", 2, rld_count[0]);
    pwr_state = STC_PWR_HIBERNATION;
    tick(2);
    pwr_state = STC_PWR_ACTIVE;
    rld_cfg = '0;
    chk("rld_count0", 0, rld_count[0]);
  endtask
  task automatic t_dual;
    // Medium clock taken from the RC source here, crystal in the reload scenario
    mp_src_rc = 1'h1;
    dual_cfg[0] = {1'h1, 1'h1, STC_MODE_PERIODIC, 1'h0, STC_PS_16, 1'h1, 32'h2};
    dual_cfg[1] = {1'h1, 1'h1, STC_MODE_ONESHOT, 1'h1, STC_PS_1, 1'h1, 32'h1};
    tick();
    dual_cfg[0].load = 1'h0;
    dual_cfg[1].load = 1'h0;
    step(1'h0, 16);
    chk("dual_count0", 1, dual_count[0]);
    chk("dual_count1", 0, dual_count[1]);
    step(1'h0, 32);
    chk("dual_count0", 2, dual_count[0]);
    chk("dual_irq", 2, evn[2]);
    dual_cfg[1] = {1'h1, 1'h1, STC_MODE_FREE, 1'h0, STC_PS_256, 1'h1, 32'h0};
    tick();
    dual_cfg[1].load = 1'h0;
    step(1'h0, 256);
    chk("dual_count1", STC_MAX16, dual_count[1]);
  endtask
  task automatic t_slow;
    slow_value = 40'h5;
    slow_load = 1'h1;
    tick();
    slow_load = 1'h0;
    slow_enable = 1'h1;
    thr_cfg[0] = {1'h1, 40'h3};
    thr_cfg[1] = {1'h1, 40'h4};
    // Disabled threshold on a value that is crossed must stay quiet
    thr_cfg[2] = {1'h0, 40'h3};
    step(1'h1, 2);
    chk("slow_count", 3, slow_count);
    chk("slow_irq0", 1, evn[3]);
    chk("slow_irq1", 1, evn[4]);
    chk("slow_irq2", 0, evn[6]);
    rd_start = 1'h1;
    tick();
    rd_start = 1'h0;
    wait_rd();
    chk("rd_val", 3, rd_val);
    // A low step under the first sample forces the third read
    rd_start = 1'h1;
    lp_xtal_clk = 1'h1;
    tick();
    rd_start = 1'h0;
    lp_xtal_clk = 1'h0;
    wait_rd();
    chk("rd_val", 2, rd_val);
  endtask
  task automatic t_wake;
    pwr_state = STC_PWR_SOC_OFF;
    lp_src_rc = 1'h1;
    wake_value = 40'h3;
    wake_load = 1'h1;
    tick();
    wake_load = 1'h0;
    wake_enable = 1'h1;
    step(1'h1, 3);
    chk("wake_count", 0, wake_count);
    chk("wake_req", 1, evn[5]);
    chk("slow_count", 2, slow_count);
    ext_wake_pin = 1'h1;
    tick();
    chk("wake_req_pin", 1, wake_req);
    ext_wake_pin = 1'h0;
    cmp_wake = 1'h1;
    tick();
    chk("wake_req_cmp", 1, wake_req);
    pwr_state = STC_PWR_ACTIVE;
    tick();
    chk("wake_req_active", 0, wake_req);
    cmp_wake = 1'h0;
  endtask

  initial begin
    tick(5);
    rst_n = 1'h1;
    tick(2);
    t_reload();
    t_dual();
    t_slow();
    t_wake();
    end_sim();
  end
endmodule // tb

// *** rtl/stc_pkg.sv ***
/*
  Shared constants and types for the timer cluster: power states, dual timer
  modes, prescale codes, widths and per-channel configuration structs.
  Assumes a single 200 MHz system clock; slow and medium timer clocks arrive
  as levels sampled on that clock.
*/
package stc_pkg;

  localparam int STC_WAKE_W = 40;
  localparam int STC_RLD_W = 32;
  localparam int STC_DUAL_W = 32;
  localparam int STC_SLOW_W = 40;
  localparam int STC_NUM_RLD = 2;
  localparam int STC_NUM_DUAL = 2;
  localparam int STC_NUM_THR = 3;
  localparam int STC_PRE_W = 8;
  localparam logic [STC_PRE_W-1:0] STC_PRE_DIV1 = 8'h00;
  localparam logic [STC_PRE_W-1:0] STC_PRE_DIV16 = 8'h0f;
  localparam logic [STC_PRE_W-1:0] STC_PRE_DIV256 = 8'hff;
  localparam logic [STC_DUAL_W-1:0] STC_MAX16 = 32'h0000_ffff;
  localparam logic [STC_DUAL_W-1:0] STC_MAX32 = 32'hffff_ffff;
  localparam logic [STC_SLOW_W-1:0] STC_SLOW_RST = 40'h00_0000_0000;
  localparam logic [STC_WAKE_W-1:0] STC_WAKE_RST = 40'h00_0000_0000;

  typedef enum logic [2:0] {
    STC_PWR_ACTIVE = 3'h0,
    STC_PWR_RETENTION = 3'h1,
    STC_PWR_HIBERNATION = 3'h2,
    STC_PWR_SOC_OFF = 3'h3,
    STC_PWR_POWERDOWN = 3'h4
  } stc_pwr_t;

  typedef enum logic [1:0] {
    STC_MODE_ONESHOT = 2'h0,
    STC_MODE_PERIODIC = 2'h1,
    STC_MODE_FREE = 2'h2
  } stc_mode_t;

  typedef enum logic [1:0] {
    STC_PS_1 = 2'h0,
    STC_PS_16 = 2'h1,
    STC_PS_256 = 2'h2
  } stc_ps_t;

  typedef struct packed {
    logic enable;
    logic irq_mask_n;
    logic [STC_RLD_W-1:0] reload;
  } stc_rld_cfg_t;

  typedef struct packed {
    logic enable;
    logic irq_mask_n;
    stc_mode_t mode;
    logic wide;
    stc_ps_t prescale;
    logic load;
    logic [STC_DUAL_W-1:0] value;
  } stc_dual_cfg_t;

  typedef struct packed {
    logic enable;
    logic [STC_SLOW_W-1:0] value;
  } stc_thr_cfg_t;

endpackage

// *** rtl/stc_timer_cluster.sv ***
/*
  Timer cluster: wakeup counter, two reload counters, dual timer and slow
  timer with three thresholds. All logic runs on clk; the low power and
  medium power timer clocks are levels synchronous to clk whose rising edges
  step the counters. Power state comes from the power controller.
*/
`timescale 1ns/1ps

// Function
// - Wakeup counter is 40 bits and steps on the low power clock.
// - Enabled in SoC off, wakeup expiry ends the off period.
// - Four timer cores: two reload, dual, slow; all counts readable.
// - Reload and dual timers use medium clock; slow timer uses low clock.
// - All general purpose timers halt in any low power state.
// - Timer state kept in retention, cleared in hibernation.
// - First reload timer counts down from reload; masked interrupt on 1 to 0.
// - At zero, reload timer loads reload value and keeps counting.
// - Second reload timer behaves like the first with own controls.
// - Dual timer has two independent counters sharing one interrupt.
// - Each dual counter counts down; one-shot, periodic or free-running.
// - Each dual counter works as 16 or 32 bits wide.
// - Per-counter prescaler divides by one, sixteen or 256.
// - Slow timer is a 40-bit down counter with three thresholds.
// - Enabled threshold interrupts on step from threshold plus one to it.
// - Slow count changes once per low power clock period.
// - Low clock: crystal or RC; medium clock: crystal or RC.
// - In SoC off, wakeup counter is one of three wake sources.
module stc_timer_cluster
  import stc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic lp_xtal_clk,
  input wire logic lp_internal_rc_osc_clk,
  input wire logic lp_src_rc,
  input wire logic mp_xtal_clk,
  input wire logic mp_internal_rc_osc_clk,
  input wire logic mp_src_rc,
  input wire stc_pwr_t pwr_state,
  input wire logic wake_enable,
  input wire logic wake_load,
  input wire logic [STC_WAKE_W-1:0] wake_value,
  input wire logic ext_wake_pin,
  input wire logic cmp_wake,
  input wire stc_rld_cfg_t [STC_NUM_RLD-1:0] rld_cfg,
  input wire stc_dual_cfg_t [STC_NUM_DUAL-1:0] dual_cfg,
  input wire logic slow_enable,
  input wire logic slow_load,
  input wire logic [STC_SLOW_W-1:0] slow_value,
  input wire stc_thr_cfg_t [STC_NUM_THR-1:0] thr_cfg,
  output logic [STC_WAKE_W-1:0] wake_count,
  output logic wake_req,
  output logic [STC_NUM_RLD-1:0][STC_RLD_W-1:0] rld_count,
  output logic [STC_NUM_RLD-1:0] rld_irq,
  output logic [STC_NUM_DUAL-1:0][STC_DUAL_W-1:0] dual_count,
  output logic dual_irq,
  output logic [STC_SLOW_W-1:0] slow_count,
  output logic [STC_NUM_THR-1:0] slow_irq
);

  logic lp_lvl;
  logic mp_lvl;
  logic lp_prev_ff;
  logic mp_prev_ff;
  logic lp_step;
  logic mp_step;
  logic gp_run;
  logic gp_clear;
  logic wake_hit;
  logic [STC_WAKE_W-1:0] wake_cnt_ff;
  logic wake_req_ff;
  logic [STC_NUM_DUAL-1:0] dual_evt;
  logic [STC_SLOW_W-1:0] slow_cnt_ff;
  logic [STC_NUM_THR-1:0] slow_irq_ff;
  logic dual_irq_ff;

  // Source selection happens upstream of the edge detect so a switch costs
  // at most one spurious step, never a stuck counter.
  assign lp_lvl = lp_src_rc ? lp_internal_rc_osc_clk : lp_xtal_clk;
  assign mp_lvl = mp_src_rc ? mp_internal_rc_osc_clk : mp_xtal_clk;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lp_prev_ff <= 1'b0;
      mp_prev_ff <= 1'b0;
    end else begin
      lp_prev_ff <= lp_lvl;
      mp_prev_ff <= mp_lvl;
    end
  end

  assign lp_step = lp_lvl & ~lp_prev_ff;
  assign mp_step = mp_lvl & ~mp_prev_ff;

  // Only the active state lets general purpose timers run; retention simply freezes them.
  assign gp_run = (pwr_state == STC_PWR_ACTIVE);
  assign gp_clear = (pwr_state == STC_PWR_HIBERNATION) ||
                    (pwr_state == STC_PWR_POWERDOWN);

  // Wakeup counter: only meaningful while the chip sits in SoC off.
  assign wake_hit = wake_enable && (pwr_state == STC_PWR_SOC_OFF) && lp_step &&
                    (wake_cnt_ff == {{(STC_WAKE_W-1){1'b0}}, 1'b1});

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_cnt_ff <= STC_WAKE_RST;
    end else if (wake_load) begin
      wake_cnt_ff <= wake_value;
    end else if (wake_enable && (pwr_state == STC_PWR_SOC_OFF) && lp_step &&
                 (wake_cnt_ff != STC_WAKE_RST)) begin
      wake_cnt_ff <= wake_cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_req_ff <= 1'b0;
    end else begin
      // Pin and comparator are the only other wake paths out of SoC off.
      wake_req_ff <= wake_hit ||
                     ((pwr_state == STC_PWR_SOC_OFF) && (ext_wake_pin || cmp_wake));
    end
  end

  assign wake_count = wake_cnt_ff;
  assign wake_req = wake_req_ff;

  // Reload counters share one body; each has its own enable, reload and mask.
  genvar gr;
  generate
    for (gr = 0; gr < STC_NUM_RLD; gr++) begin : g_rld
      logic [STC_RLD_W-1:0] cnt_ff;
      logic irq_ff;
      logic step;

      assign step = gp_run && mp_step && rld_cfg[gr].enable;

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt_ff <= '0;
        end else if (gp_clear) begin
          cnt_ff <= '0;
        end else if (step) begin
          if (cnt_ff == '0) begin
            cnt_ff <= rld_cfg[gr].reload;
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
      end

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          irq_ff <= 1'b0;
        end else begin
          irq_ff <= step && !gp_clear && (cnt_ff == 32'h0000_0001) &&
                    rld_cfg[gr].irq_mask_n;
        end
      end

      assign rld_count[gr] = cnt_ff;
      assign rld_irq[gr] = irq_ff;
    end
  endgenerate

  // Dual timer channels run fully independently.
  genvar gd;
  generate
    for (gd = 0; gd < STC_NUM_DUAL; gd++) begin : g_dual
      logic [STC_DUAL_W-1:0] cnt_ff;
      logic [STC_PRE_W-1:0] pre_ff;
      logic [STC_PRE_W-1:0] pre_top;
      logic [STC_DUAL_W-1:0] max_val;
      logic [STC_DUAL_W-1:0] nxt_cnt;
      logic tick;

      always_comb begin
        case (dual_cfg[gd].prescale)
          STC_PS_1: pre_top = STC_PRE_DIV1;
          STC_PS_16: pre_top = STC_PRE_DIV16;
          STC_PS_256: pre_top = STC_PRE_DIV256;
          default: pre_top = STC_PRE_DIV1;
        endcase
      end

      assign max_val = dual_cfg[gd].wide ? STC_MAX32 : STC_MAX16;

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pre_ff <= '0;
        end else if (gp_clear || dual_cfg[gd].load) begin
          pre_ff <= '0;
        end else if (gp_run && mp_step && dual_cfg[gd].enable) begin
          pre_ff <= (pre_ff >= pre_top) ? '0 : pre_ff + 1'b1;
        end
      end

      assign tick = gp_run && mp_step && dual_cfg[gd].enable &&
                    (pre_ff >= pre_top);

      always_comb begin
        nxt_cnt = cnt_ff;
        if (cnt_ff == '0) begin
          case (dual_cfg[gd].mode)
            STC_MODE_ONESHOT: nxt_cnt = '0;
            STC_MODE_PERIODIC: nxt_cnt = dual_cfg[gd].value & max_val;
            STC_MODE_FREE: nxt_cnt = max_val;
            default: nxt_cnt = '0;
          endcase
        end else begin
          nxt_cnt = (cnt_ff - 1'b1) & max_val;
        end
      end

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt_ff <= '0;
        end else if (gp_clear) begin
          cnt_ff <= '0;
        end else if (dual_cfg[gd].load) begin
          cnt_ff <= dual_cfg[gd].value & max_val;
        end else if (tick) begin
          cnt_ff <= nxt_cnt;
        end
      end

      assign dual_evt[gd] = tick && !gp_clear && !dual_cfg[gd].load &&
                            (cnt_ff == 32'h0000_0001) && dual_cfg[gd].irq_mask_n;
      assign dual_count[gd] = cnt_ff;
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dual_irq_ff <= 1'b0;
    end else begin
      dual_irq_ff <= |dual_evt;
    end
  end

  assign dual_irq = dual_irq_ff;

  // Slow timer steps once per low power period; software must read it twice
  // because the count may move between two reads of a wide value.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_cnt_ff <= STC_SLOW_RST;
    end else if (gp_clear) begin
      slow_cnt_ff <= STC_SLOW_RST;
    end else if (slow_load) begin
      slow_cnt_ff <= slow_value;
    end else if (gp_run && slow_enable && lp_step) begin
      slow_cnt_ff <= slow_cnt_ff - 1'b1;
    end
  end

  genvar gt;
  generate
    for (gt = 0; gt < STC_NUM_THR; gt++) begin : g_thr
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          slow_irq_ff[gt] <= 1'b0;
        end else begin
          slow_irq_ff[gt] <= thr_cfg[gt].enable && gp_run && slow_enable && lp_step &&
                             !gp_clear && !slow_load &&
                             (slow_cnt_ff == thr_cfg[gt].value + 1'b1);
        end
      end
    end
  endgenerate

  assign slow_count = slow_cnt_ff;
  assign slow_irq = slow_irq_ff;

endmodule // stc_timer_cluster
